// >>> verilog/usfs_defines.svh
// Purpose: offsets, field positions, reset values and counts for usfs
// Assumes: included by bare name from usfs_clkgen, usfs_usart and tb_top
// Notes: register bytes sit in the low bits of a 32-bit apb word
`ifndef USFS_DEFINES_SVH
`define USFS_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define USFS_OFF_DATA 8'h00
`define USFS_OFF_STAT 8'h04
`define USFS_OFF_CTLB 8'h08
`define USFS_OFF_CTLC 8'h0c
`define USFS_OFF_BAUD 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define USFS_ST_UDRE 0
`define USFS_ST_TXC 1
`define USFS_ST_RXC 2
`define USFS_ST_FE 3
`define USFS_ST_PE 4
`define USFS_ST_DOR 5
`define USFS_ST_U2X 6
`define USFS_B_TX_ENABLE_BIT 0
`define USFS_B_RXEN 1
`define USFS_B_CSZ2 2
`define USFS_B_TXB8 3
`define USFS_B_RXB8 4
`define USFS_C_SYNC 0
`define USFS_C_PM 1
`define USFS_C_SBS 3
`define USFS_C_CSZ 4
`define USFS_C_CPOL 6
`define USFS_C_XDIR 7

// ----------------------------------------------------------------
// reset values and division counts
// ----------------------------------------------------------------
`define USFS_CSZ_RST 3'h3
`define USFS_BAUD_RST 12'h000
`define USFS_DIV_NORM 4'hf
`define USFS_DIV_DBL 4'h7
`define USFS_HALF_NORM 4'h7
`define USFS_HALF_DBL 4'h3

`endif

// >>> verilog/usfs_pkg.sv
// Purpose: shared types of the usfs serial frame engine
// Assumes: constants live in usfs_defines.svh
// Notes: frame format is one record for transmitter and receiver
package usfs_pkg;

    // shared frame and clock configuration
    typedef struct packed {
        logic sync;
        logic xdir;
        logic cpol;
        logic u2x;
        logic [1:0] pmode;
        logic sbs;
        logic [2:0] csz;
    } usfs_cfg_t;

    typedef enum logic [1:0] {
        USFS_RX_IDLE,
        USFS_RX_START,
        USFS_RX_BITS
    } usfs_rx_st_t;

    // clock unit state
    typedef struct packed {
        logic [11:0] cnt;
        logic tick;
        logic s1;
        logic s2;
        logic s3;
        logic xck;
        logic [3:0] div;
        logic tx_en;
        logic smp_en;
    } usfs_ck_t;

    // frame engine state
    typedef struct packed {
        usfs_cfg_t cfg;
        logic tx_enable_bit;
        logic rxen;
        logic txb8;
        logic [11:0] baud;
        logic baud_load;
        logic [8:0] tbuf;
        logic tbuf_full;
        logic txc;
        logic [12:0] tsr;
        logic [3:0] tleft;
        logic tbusy;
        logic txd;
        logic txd_oe;
        logic xck_oe;
        usfs_rx_st_t rst;
        logic [3:0] rcnt;
        logic [3:0] ridx;
        logic [10:0] rfr;
        logic [8:0] rbuf;
        logic rxfull;
        logic fe;
        logic pe;
        logic dor;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } usfs_st_t;

endpackage

// >>> verilog/usfs_clkgen.sv
// Purpose: baud counter, transfer clock sync and bit-rate enables
// Assumes: one system clock; config held steady while a frame runs
// Notes: all enables are one-cycle pulses, registered
`timescale 1ns/10ps
`include "usfs_defines.svh"

module usfs_clkgen
    import usfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire usfs_cfg_t cfg_i,
    input wire logic [11:0] baud_i,
    input wire logic baud_load_i,
    input wire logic xck_i,
    output logic tick_o,
    output logic tx_en_o,
    output logic smp_en_o,
    output logic xck_o
);

    usfs_ck_t q;
    usfs_ck_t n;
    logic master;
    logic rise;
    logic fall;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        master = cfg_i.sync & cfg_i.xdir;
        rise = q.s2 & ~q.s3;
        fall = ~q.s2 & q.s3;
        n.tx_en = 1'b0;
        n.smp_en = 1'b0;
        // down-counter reloads at zero or on divisor write
        n.tick = (q.cnt == 12'h000);
        if (baud_load_i || q.cnt == 12'h000) begin
            n.cnt = baud_i;
        end else begin
            n.cnt = q.cnt - 12'h001;
        end
        // two-stage sync, s1 feeds s2 only
        n.s1 = xck_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (!cfg_i.sync) begin
            n.xck = 1'b0;
            if (q.tick) begin
                if (q.div >= (cfg_i.u2x ? `USFS_DIV_DBL : `USFS_DIV_NORM)) begin
                    n.div = 4'h0;
                    n.tx_en = 1'b1;
                end else begin
                    n.div = q.div + 4'h1;
                end
            end
        end else if (master) begin
            // master toggles the pin each tick: divide by two
            if (q.tick) begin
                n.xck = ~q.xck;
                n.tx_en = ~q.xck ^ cfg_i.cpol;
                n.smp_en = q.xck ^ cfg_i.cpol;
            end
        end else begin
            // slave: edges seen two cycles late, hence f/4 limit
            n.xck = 1'b0;
            n.tx_en = cfg_i.cpol ? fall : rise;
            n.smp_en = cfg_i.cpol ? rise : fall;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.cnt <= `USFS_BAUD_RST;
        end else begin
            q <= n;
        end
    end

    assign tick_o = q.tick;
    assign tx_en_o = q.tx_en;
    assign smp_en_o = q.smp_en;
    assign xck_o = q.xck;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_SLAVE_DELAY: assert property (
        (cfg_i.sync && !cfg_i.xdir && !cfg_i.cpol && $rose(xck_i))
        ##1 (xck_i && cfg_i.sync && !cfg_i.xdir && !cfg_i.cpol)[*2]
        |-> ##1 tx_en_o)
        else $error("slave change edge not seen three cycles later");
    AST_MASTER_EDGE: assert property (
        $past(master) && tx_en_o |-> xck_o != $past(cfg_i.cpol))
        else $error("master data change on wrong clock edge");
    AST_MASTER_DIV: assert property (
        master && q.tick && $stable(cfg_i) |=> $changed(xck_o))
        else $error("master clock did not toggle on tick");

endmodule

// >>> verilog/usfs_usart.sv
// Purpose: usart frame engine with apb registers, tx and rx paths
// Assumes: serial inputs synchronous to sys_clk_i; apb3 slave
// Notes: one wait state per apb access; single-level rx buffer
//
// How it works
// - external transfer clock passes a sync register and edge detector
// - sync mode: clock pin is input as slave, output as master
// - sync mode samples input on the edge opposite the change edge
// - polarity clear: change on rising, sample on falling; set reverses
// - all thirty formats: 5-9 data, none/even/odd parity, 1-2 stops
// - start bit, data lsb first, optional parity, then stop bits
// - start low, stops high; idle line high or next frame at once
// - transmitter and receiver share one frame format setting
// - receiver checks only first stop bit for framing error
// - parity is xor of data bits, inverted for odd
// - char size, parity mode and stop select fields set the format
// - tx enable hands the serial output pin to the transmitter
// - sync master with tx or rx enabled takes over the transfer clock pin
// - cpu write to data buffer loads it and starts sending
// - buffer moves to shifter when idle or right after last stop
// - shifter sends a whole frame at the selected bit rate
// - unused high bits of short characters are ignored
// - baud down-counter reloads at zero or divisor write, ticks
// - tx divides tick by 16, 8 or 2 by mode
// - clock pin direction selects sync master or sync slave
`timescale 1ns/10ps
`include "usfs_defines.svh"

module usfs_usart
    import usfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    input wire logic xfer_clock_pin_i,
    output logic xfer_clock_pin_o,
    output logic xfer_clock_pin_oe_o
);

    usfs_st_t q;
    usfs_st_t n;
    logic ck_tick;
    logic ck_tx_en;
    logic ck_smp_en;
    logic acc;
    logic wr;
    logic rd;
    logic smp;
    logic [3:0] nb;
    logic [3:0] last;
    logic [8:0] rdat;
    logic [12:0] fr;

    // ----------------------------------------------------------------
    // format helpers
    // ----------------------------------------------------------------
    // reserved sizes fall back to eight bits
    function automatic logic [3:0] nbits(input logic [2:0] c);
        case (c)
            3'h0: nbits = 4'h5;
            3'h1: nbits = 4'h6;
            3'h2: nbits = 4'h7;
            3'h7: nbits = 4'h9;
            default: nbits = 4'h8;
        endcase
    endfunction

    function automatic logic [8:0] dmask(input logic [3:0] k);
        dmask = 9'(({1'b0, 9'h000} | 10'h001) << k) - 9'h001;
    endfunction

    // start, data lsb first, parity, stops; unused slots stay high
    function automatic logic [12:0] frame(input logic [8:0] d,
                                          input usfs_cfg_t c);
        logic [3:0] k;
        logic [8:0] m;
        logic [12:0] f;
        k = nbits(c.csz);
        m = d & dmask(k);
        f = 13'h1fff;
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < k) begin
                f[i + 1] = m[i];
            end
        end
        if (c.pmode[1]) begin
            f[4'(k + 4'h1)] = ^m ^ c.pmode[0];
        end
        frame = f;
    endfunction

    // ----------------------------------------------------------------
    // clock unit
    // ----------------------------------------------------------------
    usfs_clkgen u_clk (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .cfg_i(q.cfg),
        .baud_i(q.baud),
        .baud_load_i(q.baud_load),
        .xck_i(xfer_clock_pin_i),
        .tick_o(ck_tick),
        .tx_en_o(ck_tx_en),
        .smp_en_o(ck_smp_en),
        .xck_o(xfer_clock_pin_o)
    );

    // ----------------------------------------------------------------
    // next state: bus, transmitter, receiver
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        nb = nbits(q.cfg.csz);
        last = 4'(nb + {3'h0, q.cfg.pmode[1]});
        acc = psel_i & penable_i & q.pready;
        wr = acc & pwrite_i;
        rd = acc & ~pwrite_i;
        fr = frame(q.tbuf, q.cfg);
        rdat = q.rfr[8:0] & dmask(nb);
        n.pready = psel_i & penable_i & ~q.pready;
        n.pslverr = 1'b0;
        n.baud_load = 1'b0;
        // read data captured one cycle before pready
        if (psel_i && penable_i && !q.pready) begin
            n.prdata = 32'h0000_0000;
            if (paddr_i == `USFS_OFF_DATA) begin
                n.prdata[7:0] = q.rbuf[7:0];
            end else if (paddr_i == `USFS_OFF_STAT) begin
                n.prdata[`USFS_ST_UDRE] = ~q.tbuf_full;
                n.prdata[`USFS_ST_TXC] = q.txc;
                n.prdata[`USFS_ST_RXC] = q.rxfull;
                n.prdata[`USFS_ST_FE] = q.fe;
                n.prdata[`USFS_ST_PE] = q.pe;
                n.prdata[`USFS_ST_DOR] = q.dor;
                n.prdata[`USFS_ST_U2X] = q.cfg.u2x;
            end else if (paddr_i == `USFS_OFF_CTLB) begin
                n.prdata[`USFS_B_TX_ENABLE_BIT] = q.tx_enable_bit;
                n.prdata[`USFS_B_RXEN] = q.rxen;
                n.prdata[`USFS_B_CSZ2] = q.cfg.csz[2];
                n.prdata[`USFS_B_TXB8] = q.txb8;
                n.prdata[`USFS_B_RXB8] = q.rbuf[8];
            end else if (paddr_i == `USFS_OFF_CTLC) begin
                n.prdata[`USFS_C_SYNC] = q.cfg.sync;
                n.prdata[`USFS_C_PM +: 2] = q.cfg.pmode;
                n.prdata[`USFS_C_SBS] = q.cfg.sbs;
                n.prdata[`USFS_C_CSZ +: 2] = q.cfg.csz[1:0];
                n.prdata[`USFS_C_CPOL] = q.cfg.cpol;
                n.prdata[`USFS_C_XDIR] = q.cfg.xdir;
            end else if (paddr_i == `USFS_OFF_BAUD) begin
                n.prdata[11:0] = q.baud;
            end else begin
                n.pslverr = 1'b1;
            end
        end
        // writes take effect at the edge that completes the access
        if (wr) begin
            if (paddr_i == `USFS_OFF_DATA) begin
                n.tbuf = {q.txb8, pwdata_i[7:0]};
                n.tbuf_full = 1'b1;
            end else if (paddr_i == `USFS_OFF_STAT) begin
                if (pwdata_i[`USFS_ST_TXC]) begin
                    n.txc = 1'b0;
                end
                n.cfg.u2x = pwdata_i[`USFS_ST_U2X];
            end else if (paddr_i == `USFS_OFF_CTLB) begin
                n.tx_enable_bit = pwdata_i[`USFS_B_TX_ENABLE_BIT];
                n.rxen = pwdata_i[`USFS_B_RXEN];
                n.cfg.csz[2] = pwdata_i[`USFS_B_CSZ2];
                n.txb8 = pwdata_i[`USFS_B_TXB8];
            end else if (paddr_i == `USFS_OFF_CTLC) begin
                // no guard: changing format mid-frame corrupts both ways
                n.cfg.sync = pwdata_i[`USFS_C_SYNC];
                n.cfg.pmode = pwdata_i[`USFS_C_PM +: 2];
                n.cfg.sbs = pwdata_i[`USFS_C_SBS];
                n.cfg.csz[1:0] = pwdata_i[`USFS_C_CSZ +: 2];
                n.cfg.cpol = pwdata_i[`USFS_C_CPOL];
                n.cfg.xdir = pwdata_i[`USFS_C_XDIR];
            end else if (paddr_i == `USFS_OFF_BAUD) begin
                n.baud = pwdata_i[11:0];
                n.baud_load = 1'b1;
            end
        end
        if (rd && paddr_i == `USFS_OFF_DATA) begin
            n.rxfull = 1'b0;
            n.dor = 1'b0;
        end
        // transmitter steps once per bit enable
        if (ck_tx_en) begin
            if (q.tbusy && q.tleft != 4'h0) begin
                n.txd = q.tsr[0];
                n.tsr = {1'b1, q.tsr[12:1]};
                n.tleft = q.tleft - 4'h1;
            end else if (q.tbuf_full && (q.tx_enable_bit || q.tbusy)) begin
                // next frame starts straight after the last stop
                n.txd = fr[0];
                n.tsr = {1'b1, fr[12:1]};
                n.tleft = 4'(last + 4'h1 + {3'h0, q.cfg.sbs});
                n.tbusy = 1'b1;
                n.tbuf_full = wr && paddr_i == `USFS_OFF_DATA;
            end else begin
                if (q.tbusy) begin
                    n.txc = 1'b1; // set beats a same-cycle clear
                end
                n.tbusy = 1'b0;
                n.txd = 1'b1;
            end
        end
        // pin stays with the transmitter until pending data is gone
        n.txd_oe = q.tx_enable_bit | q.tbusy | q.tbuf_full;
        n.xck_oe = q.cfg.sync & q.cfg.xdir & (q.tx_enable_bit | q.rxen);
        // receiver: sync uses the sample edge, async mid-bit ticks
        smp = q.cfg.sync ? ck_smp_en : (ck_tick && q.rcnt == 4'h0);
        case (q.rst)
            USFS_RX_IDLE: begin
                n.ridx = 4'h0;
                if (q.rxen && !serial_in_pin_i) begin
                    if (!q.cfg.sync) begin
                        n.rst = USFS_RX_START;
                        n.rcnt = q.cfg.u2x ? `USFS_HALF_DBL : `USFS_HALF_NORM;
                    end else if (ck_smp_en) begin
                        n.rst = USFS_RX_BITS;
                    end
                end
            end
            USFS_RX_START: begin
                if (ck_tick) begin
                    if (q.rcnt != 4'h0) begin
                        n.rcnt = q.rcnt - 4'h1;
                    end else if (serial_in_pin_i) begin
                        n.rst = USFS_RX_IDLE; // false start, line back high
                    end else begin
                        n.rst = USFS_RX_BITS;
                        n.rcnt = q.cfg.u2x ? `USFS_DIV_DBL : `USFS_DIV_NORM;
                    end
                end
            end
            USFS_RX_BITS: begin
                if (!q.cfg.sync && ck_tick) begin
                    n.rcnt = (q.rcnt == 4'h0) ?
                        (q.cfg.u2x ? `USFS_DIV_DBL : `USFS_DIV_NORM) :
                        q.rcnt - 4'h1;
                end
                if (smp) begin
                    n.rfr[q.ridx] = serial_in_pin_i;
                    n.ridx = q.ridx + 4'h1;
                    if (q.ridx == last) begin
                        // second stop bit is never looked at
                        n.rst = USFS_RX_IDLE;
                        n.rbuf = rdat;
                        n.fe = ~serial_in_pin_i;
                        n.pe = q.cfg.pmode[1] &
                            (^rdat ^ q.cfg.pmode[0] ^ q.rfr[nb]);
                        n.dor = q.rxfull | n.dor;
                        n.rxfull = 1'b1;
                    end
                end
            end
            default: n.rst = USFS_RX_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // state register and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.txd <= 1'b1;
            q.cfg.csz <= `USFS_CSZ_RST;
            q.baud <= `USFS_BAUD_RST;
        end else begin
            q <= n;
        end
    end

    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign serial_out_pin_o = q.txd;
    assign serial_out_pin_oe_o = q.txd_oe;
    assign xfer_clock_pin_oe_o = q.xck_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_START_LOW: assert property (
        $rose(q.tbusy) |-> !q.txd && q.tleft >= 4'h6)
        else $error("frame did not open with a low start bit");
    AST_IDLE_HIGH: assert property (
        !q.tbusy |-> q.txd)
        else $error("idle line not high");
    AST_LOAD: assert property (
        wr && paddr_i == `USFS_OFF_DATA |=> q.tbuf_full)
        else $error("data write did not fill the buffer");
    AST_BACK2BACK: assert property (
        ck_tx_en && q.tbusy && q.tleft == 4'h0 && q.tbuf_full
        |=> q.tbusy && !q.txd)
        else $error("next frame not started after last stop");
    AST_PARITY: assert property (
        $rose(q.tbusy) && q.cfg.pmode[1] && $stable(q.cfg) |->
        q.tsr[nb] == (^($past(q.tbuf) & dmask(nb)) ^ q.cfg.pmode[0]))
        else $error("wrong parity bit loaded");
    AST_MASK: assert property (
        $rose(q.tbusy) && q.cfg.csz == 3'h0 && !q.cfg.pmode[1]
        |-> q.tsr[12:5] == 8'hff)
        else $error("unused high data bits reached the frame");
    AST_FRAMING: assert property (
        $rose(q.rxfull) |-> q.fe == !$past(serial_in_pin_i))
        else $error("framing flag does not follow first stop bit");
    AST_OE: assert property (
        q.tx_enable_bit |=> q.txd_oe)
        else $error("enabled transmitter does not drive its pin");
    AST_XCK_OE: assert property (
        q.cfg.sync && q.cfg.xdir && q.tx_enable_bit |=> xfer_clock_pin_oe_o)
        else $error("master clock pin not driven");
    AST_BUSY_BOUND: assert property (
        $rose(q.tbusy) && !q.cfg.sync && q.baud == 12'h000
        && !q.cfg.u2x |-> ##[1:300] !q.tbusy || q.tbuf_full)
        else $error("frame did not finish in time");

    COV_B2B: cover property (ck_tx_en && q.tleft == 4'h0 && q.tbuf_full);
    COV_FE: cover property ($rose(q.rxfull) && n.fe);
    COV_SYNC_TX: cover property ($rose(q.tbusy) && q.cfg.sync);
    COV_PAR: cover property ($rose(q.rxfull) && q.cfg.pmode[1]);

endmodule

// >>> sim/usfs_peer.sv
// Purpose: serial peer on the usfs transmit and receive data lines
// Assumes: async bits last bit_cyc clocks; sync bits follow the pin
// Notes: captures transmitted frames, sends frames lsb first
`timescale 1ns/10ps

module usfs_peer (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic xck_i,
    output logic rx_o,
    output logic xclk_o
);
    int bit_cyc = 16;

    // ----------------------------------------------------------------
    // line idle and frame tasks
    // ----------------------------------------------------------------
    // line rests high between frames
    initial rx_o = 1'b1;
    initial xclk_o = 1'b0;

    // wait for a start edge, bounded, then sample each bit mid-way
    task automatic grab(input int n, output logic [15:0] v);
        int k;
        v = 16'h0;
        k = 0;
        while (line_i !== 1'b0 && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        repeat (bit_cyc / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            v[i] = line_i;
            repeat (bit_cyc) @(posedge clk_i);
        end
    endtask

    // bit 0 of v is the start bit; line returns high afterwards
    task automatic send(input int n, input logic [15:0] v);
        for (int i = 0; i < n; i++) begin
            rx_o <= v[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        rx_o <= 1'b1;
    endtask

    // sync capture on the sample edge; as slave clock source it runs
    // only inside the frame, sixteen system clocks a period
    task automatic sgrab(input int n, input logic pol, input logic drv,
                         output logic [15:0] v);
        logic p;
        int i, k;
        v = 16'hffff;
        p = xck_i;
        i = 0;
        k = 0;
        while (i < n && k < 3000) begin
            @(posedge clk_i);
            k++;
            if (drv && k % 8 == 0) begin
                xclk_o <= ~xclk_o;
            end
            if (xck_i != p && xck_i == pol && (i > 0 || !line_i)) begin
                v[i] = line_i;
                i++;
            end
            p = xck_i;
        end
    endtask
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the usfs frame engine
// Assumes: baud divisor 0 at normal speed, so 16 clocks a bit
// Notes: sync frames are caught on the peer's sample edge
`timescale 1ns/10ps
`include "usfs_defines.svh"

module tb_top;
    import usfs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sout, sout_oe, xck, xck_oe, sin, er;
    logic [15:0] cap;
    logic xpin, xclk;
    int n_fail = 0;
    int checks = 0;

    usfs_usart dut (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_in_pin_i(sin),
        .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe),
        .xfer_clock_pin_i(xpin), .xfer_clock_pin_o(xck),
        .xfer_clock_pin_oe_o(xck_oe));
    usfs_peer peer (.clk_i(clk), .line_i(sout), .rx_o(sin), .xck_i(xpin),
        .xclk_o(xclk));

    // the pin carries the master clock when driven, else the peer's
    assign xpin = xck_oe ? xck : xclk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    initial forever #2 clk = ~clk;

    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40) begin
            n_fail++;
            tally_and_finish;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected frame bits, start at bit 0, ones above the last stop
    function automatic logic [15:0] frame(input int nd, input logic [1:0] pm,
                                          input logic [8:0] d);
        logic [15:0] v;
        logic p;
        v = 16'hffff;
        v[0] = 1'b0;
        p = pm[0];
        for (int k = 0; k < nd; k++) begin
            v[k + 1] = d[k];
            p = p ^ d[k];
        end
        if (pm[1]) v[nd + 1] = p;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk(sout, 1'b1);
        chk(sout_oe, 1'b0);
        apb(1'b0, `USFS_OFF_CTLC, 32'h0);
        chk(rd, 32'h30);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask

    // formats at idle; high bits above the size must not show
    task automatic t_tx;
        logic [2:0] cz[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        logic [1:0] pm[5] = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b11};
        logic sb[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [8:0] dt[5] = '{9'h1ff, 9'h0b5, 9'h06d, 9'h0a5, 9'h1c3};
        int nd, n;
        logic [31:0] m;
        for (int i = 0; i < 5; i++) begin
            nd = (cz[i] == 3'h7) ? 9 : int'(cz[i]) + 5;
            n = nd + int'(pm[i][1]) + int'(sb[i]) + 3;
            m = (32'h1 << n) - 32'h1;
            apb(1'b1, `USFS_OFF_STAT, {25'h0, i == 0, 4'h0, 2'b10});
            peer.bit_cyc = (i == 0) ? 8 : 16;
            apb(1'b1, `USFS_OFF_CTLC, {24'h0, 2'b00, cz[i][1:0], sb[i],
                pm[i], 1'b0});
            apb(1'b1, `USFS_OFF_CTLB, {28'h0, dt[i][8], cz[i][2], 2'b11});
            apb(1'b1, `USFS_OFF_DATA, {23'h0, dt[i]});
            chk(sout_oe, 1'b1);
            peer.grab(n, cap);
            chk({16'h0, cap} & m, {16'h0, frame(nd, pm[i], dt[i])} & m);
            apb(1'b0, `USFS_OFF_STAT, 32'h0);
            chk(rd[6:0], {i == 0, 6'h03});
        end
    endtask

    // sync master at both polarities, then slave fed by the peer clock
    task automatic t_sync;
        apb(1'b1, `USFS_OFF_BAUD, 32'h1);
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, `USFS_OFF_CTLC,
                {24'h0, p != 2, p == 1, 6'h31});
            apb(1'b1, `USFS_OFF_DATA, 32'h5a);
            chk(xck_oe, p != 2);
            peer.sgrab(11, p == 1, p == 2, cap);
            chk({16'h0, cap}, {16'h0, frame(8, 2'b00, 9'h05a)});
        end
    endtask

    // first stop low flags a framing error, a good frame does not
    task automatic t_rx;
        apb(1'b1, `USFS_OFF_CTLB, 32'h3);
        apb(1'b1, `USFS_OFF_CTLC, 32'h38);
        for (int f = 0; f < 2; f++) begin
            peer.send(11, {5'h0, 1'b1, f[0], 8'h3c, 1'b0});
            repeat (40) @(posedge clk);
            apb(1'b0, `USFS_OFF_STAT, 32'h0);
            chk(rd[3:2], {~f[0], 1'b1});
            apb(1'b0, `USFS_OFF_DATA, 32'h0);
            chk(rd, 32'h3c);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_tx;
        t_rx;
        t_sync;
        tally_and_finish;
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
endmodule
